// file: rtl/gist_map.vh
// tracker constants: map, fields, codes
`ifndef GIST_MAP_VH
`define GIST_MAP_VH

// ==========================================================
// register byte addresses
`define GIST_ADDR_CONFIG 8'h00
`define GIST_ADDR_OP 8'h04
`define GIST_ADDR_STATUS 8'h08
`define GIST_ADDR_ERROR 8'h0c
`define GIST_ADDR_COUNT 8'h10

// ==========================================================
// config register fields
`define GIST_CFG_PAD_LO 0
`define GIST_CFG_PAD_HI 4
`define GIST_CFG_SAD_LO 8
`define GIST_CFG_SAD_HI 12
`define GIST_CFG_SEC_EN 16
`define GIST_CFG_SYSCTRL_EN 17
`define GIST_CFG_PPOLL_CAP 18
`define GIST_CFG_RESET 32'h0000_0000

// ==========================================================
// operation register fields
`define GIST_OP_CODE_LO 0
`define GIST_OP_CODE_HI 3
`define GIST_OP_MASK_LO 16
`define GIST_OP_MASK_HI 31

// ==========================================================
// host operation codes
`define GIST_OP_CMD 4'h0
`define GIST_OP_READ 4'h1
`define GIST_OP_WRITE 4'h2
`define GIST_OP_PPOLL 4'h3
`define GIST_OP_SIC 4'h4
`define GIST_OP_PASS 4'h5
`define GIST_OP_WAIT 4'h6
`define GIST_OP_DEVOP 4'h7

// ==========================================================
// error codes
`define GIST_ERR_SYSTEM 4'h0
`define GIST_ERR_NOT_CIC 4'h1
`define GIST_ERR_NO_LISTENER 4'h2
`define GIST_ERR_ADDRESSING 4'h3
`define GIST_ERR_NOT_SYSCTRL 4'h5
`define GIST_ERR_ABORTED 4'h6
`define GIST_ERR_CAPABILITY 4'hb
`define GIST_ERR_CMD_TIMEOUT 4'he

// ==========================================================
// engine result codes
`define GIST_RES_OK 3'h0
`define GIST_RES_NO_LISTENER 3'h1
`define GIST_RES_TIMEOUT 3'h2
`define GIST_RES_CMD_TIMEOUT 3'h3
`define GIST_RES_SYSFAIL 3'h4

// ==========================================================
// status word bit positions
`define GIST_ST_ERR 15
`define GIST_ST_TIMO 14
`define GIST_ST_SRQI 12
`define GIST_ST_CMPL 8
`define GIST_ST_CIC 5
`define GIST_ST_ATN 4
`define GIST_ST_TALK 3
`define GIST_ST_LISTEN 2
`define GIST_ST_TRIG 1
`define GIST_ST_CLEAR 0

// ==========================================================
// bus command bytes (seven bits, parity ignored)
`define GIST_CMD_GET 7'h08
`define GIST_CMD_DCL 7'h14
`define GIST_CMD_SDC 7'h04
`define GIST_CMD_UNL 7'h3f
`define GIST_CMD_UNT 7'h5f
`define GIST_GRP_LISTEN 2'b01
`define GIST_GRP_TALK 2'b10
`define GIST_GRP_SECOND 2'b11
`define GIST_UNADDR 5'h1f

`endif

// file: rtl/gist_status_tracker.v
// interface status tracker
// Function
// - controller flag set by clear or handover
// - controller flag cleared by IFC or handover
// - attention flag follows ATN
// - talker flag set on own talk address
// - talker cleared: UNT, own listen, other talk, IFC
// - listener flag set on own listen address
// - listener cleared: UNL, own talk, IFC
// - trigger flag set on GET as listener
// - trigger flag cleared after masked wait
// - clear flag set on DCL, SDC as listener
// - clear flag cleared after masked wait or transfer
// - code 0 system failure, detail in count
// - code 1 bus operation while not controller
// - code 2 no listeners or ATN in write
// - code 3 controller not addressed itself
// - code 5 no system controller capability
// - code 6 transfer aborted or cleared
// - code 11 capability missing or disabled
// - code 14 command byte timeout
// - count holds bytes moved
// - error bit follows operation outcome
// - status word updated each operation
`timescale 1ns/100ps
`default_nettype none
`include "gist_map.vh"

module gist_status_tracker (
    input wire clk_sys,
    input wire srst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire atnPin,
    input wire ifcPin,
    input wire srqPin,
    input wire [7:0] busByte,
    input wire busByteAccepted,
    input wire controlPassedIn,
    output reg engineStart,
    output reg [3:0] engineOpCode,
    input wire xferDone,
    input wire [2:0] xferResult,
    input wire [31:0] xferCount,
    output wire [15:0] statusWord,
    output wire opBusy
);

    // ==========================================================
    // operation sequencer states
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ENGINE = 2'd1;
    localparam [1:0] ST_WAIT = 2'd2;

    // ==========================================================
    // primary address decode, shared by talk and listen
    function isPrimary;
        input [6:0] b;
        input [1:0] grp;
        begin
            isPrimary = (b[6:5] == grp) && (b[4:0] != `GIST_UNADDR);
        end
    endfunction

    // ==========================================================
    // synchronised bus lines
    wire [2:0] lineSync; // atn, ifc, srq after two flops
    wire atnLine;
    wire ifcLine;
    wire srqLine;

    gist_sync #(.WIDTH(3)) uSync (
        .clk_sys(clk_sys),
        .srst(srst),
        .asyncIn({atnPin, ifcPin, srqPin}),
        .syncOut(lineSync)
    );

    assign atnLine = lineSync[2];
    assign ifcLine = lineSync[1];
    assign srqLine = lineSync[0];

    // ==========================================================
    // state registers
    reg [31:0] config_q; // address, secondary, capabilities
    reg [15:0] waitMask_q; // mask of the wait in progress
    reg [3:0] opCode_q; // operation in progress
    reg [1:0] state_q; // sequencer state
    reg cic_q; // controller in charge
    reg talk_q; // talker addressed
    reg listen_q; // listener addressed
    reg trig_q; // trigger detected
    reg clr_q; // clear detected
    reg pendTalk_q; // own talk seen, secondary awaited
    reg pendListen_q; // own listen seen, secondary awaited
    reg armTrig_q; // clear trigger flag on next operation
    reg armClr_q; // clear device-clear flag on next operation
    reg err_q; // error bit of the status word
    reg timo_q; // time limit bit
    reg [3:0] errCode_q; // error code
    reg [31:0] count_q; // transfer count
    reg dclAbort_q; // device clear seen during a transfer
    reg atnAbort_q; // ATN from another controller during a write
    reg atnPrev_q; // previous synchronised ATN level

    wire [4:0] ownPad = config_q[`GIST_CFG_PAD_HI:`GIST_CFG_PAD_LO];
    wire [4:0] ownSad = config_q[`GIST_CFG_SAD_HI:`GIST_CFG_SAD_LO];
    wire secEn = config_q[`GIST_CFG_SEC_EN];
    wire sysCtrlEn = config_q[`GIST_CFG_SYSCTRL_EN];
    wire ppollCap = config_q[`GIST_CFG_PPOLL_CAP];

    // ==========================================================
    // command byte decode; only ATN bytes count
    wire cmdByte = busByteAccepted && atnLine;
    wire [6:0] cb = busByte[6:0];
    wire isListen = isPrimary(cb, `GIST_GRP_LISTEN);
    wire isTalk = isPrimary(cb, `GIST_GRP_TALK);
    wire isSecond = cb[6:5] == `GIST_GRP_SECOND;
    wire ownListen = cmdByte && isListen && (cb[4:0] == ownPad);
    wire ownTalk = cmdByte && isTalk && (cb[4:0] == ownPad);
    wire secMatch = cmdByte && isSecond && (cb[4:0] == ownSad);
    wire secOther = cmdByte && isSecond && (cb[4:0] != ownSad);
    wire cmdUnl = cmdByte && (cb == `GIST_CMD_UNL);
    wire cmdUnt = cmdByte && (cb == `GIST_CMD_UNT);
    wire cmdGet = cmdByte && (cb == `GIST_CMD_GET);
    wire cmdDcl = cmdByte && (cb == `GIST_CMD_DCL);
    wire cmdSdc = cmdByte && (cb == `GIST_CMD_SDC);

    // secondary enable defers the set
    wire talkSet = secEn ? (pendTalk_q && secMatch) : ownTalk;
    wire listenSet = secEn ? (pendListen_q && secMatch) : ownListen;
    wire talkClr = cmdUnt || ownListen || (cmdByte && isTalk && !ownTalk)
        || (pendTalk_q && secOther);
    wire listenClr = cmdUnl || ownTalk;
    wire trigSet = cmdGet && listen_q;
    wire clrSet = cmdDcl || (cmdSdc && listen_q);

    // ==========================================================
    // status word: live bits and latched result
    wire idle = state_q == ST_IDLE;
    reg [15:0] status;

    // compose the status word
    always @* begin
        status = 16'h0000;
        status[`GIST_ST_ERR] = err_q;
        status[`GIST_ST_TIMO] = timo_q;
        status[`GIST_ST_SRQI] = cic_q && srqLine;
        status[`GIST_ST_CMPL] = idle;
        status[`GIST_ST_CIC] = cic_q;
        status[`GIST_ST_ATN] = atnLine;
        status[`GIST_ST_TALK] = talk_q;
        status[`GIST_ST_LISTEN] = listen_q;
        status[`GIST_ST_TRIG] = trig_q;
        status[`GIST_ST_CLEAR] = clr_q;
    end

    assign statusWord = status;
    assign opBusy = !idle;

    // ==========================================================
    // apb decode; registers answer with no wait state
    wire apbSetup = psel && !penable;
    wire apbAccess = psel && penable;
    wire opWrite = apbAccess && pwrite && (paddr == `GIST_ADDR_OP);
    wire cfgWrite = apbAccess && pwrite && (paddr == `GIST_ADDR_CONFIG);
    wire [3:0] newOp = pwdata[`GIST_OP_CODE_HI:`GIST_OP_CODE_LO];
    // ops written while busy are dropped
    wire opStart = opWrite && idle;

    assign pready = 1'b1;

    // read data and error answer captured in the setup cycle
    always @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            pslverr <= 1'b0;
            case (paddr)
                `GIST_ADDR_CONFIG: prdata <= config_q;
                `GIST_ADDR_OP: prdata <= {waitMask_q, 11'h000, !idle, opCode_q};
                `GIST_ADDR_STATUS: prdata <= {16'h0000, status};
                `GIST_ADDR_ERROR: prdata <= {28'h0000000, errCode_q};
                `GIST_ADDR_COUNT: prdata <= count_q;
                default: begin
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1; // unmapped address
                end
            endcase
        end
    end

    // ==========================================================
    // checks made before an operation reaches the engine
    reg preFail;
    reg [3:0] preCode;

    // checked in priority order
    always @* begin
        preFail = 1'b0;
        preCode = `GIST_ERR_SYSTEM;
        if (newOp == `GIST_OP_SIC && !sysCtrlEn) begin
            preFail = 1'b1;
            preCode = `GIST_ERR_NOT_SYSCTRL;
        end else if ((newOp == `GIST_OP_CMD || newOp == `GIST_OP_PPOLL
                || newOp == `GIST_OP_DEVOP || newOp == `GIST_OP_PASS) && !cic_q) begin
            preFail = 1'b1;
            preCode = `GIST_ERR_NOT_CIC;
        end else if (newOp == `GIST_OP_PPOLL && !ppollCap) begin
            preFail = 1'b1;
            preCode = `GIST_ERR_CAPABILITY;
        end else if (cic_q && ((newOp == `GIST_OP_READ && !listen_q)
                || (newOp == `GIST_OP_WRITE && !talk_q))) begin
            preFail = 1'b1;
            preCode = `GIST_ERR_ADDRESSING;
        end else if (newOp == `GIST_OP_WRITE && !cic_q && !talk_q) begin
            preFail = 1'b1;
            preCode = `GIST_ERR_NO_LISTENER;
        end
    end

    // ==========================================================
    // engine result mapping at the end of a transfer
    reg engFail;
    reg engTimo;
    reg [3:0] engCode;
    wire ioOp = opCode_q == `GIST_OP_READ || opCode_q == `GIST_OP_WRITE;

    // tracker aborts override the engine
    always @* begin
        engFail = 1'b1;
        engTimo = 1'b0;
        engCode = `GIST_ERR_SYSTEM;
        if (dclAbort_q) begin
            engCode = `GIST_ERR_ABORTED;
        end else if (atnAbort_q) begin
            engCode = `GIST_ERR_NO_LISTENER;
        end else begin
            case (xferResult)
                `GIST_RES_OK: engFail = 1'b0;
                `GIST_RES_NO_LISTENER: engCode = `GIST_ERR_NO_LISTENER;
                `GIST_RES_TIMEOUT: begin
                    engCode = `GIST_ERR_ABORTED;
                    engTimo = 1'b1;
                end
                `GIST_RES_CMD_TIMEOUT: begin
                    engCode = `GIST_ERR_CMD_TIMEOUT;
                    engTimo = 1'b1;
                end
                default: engCode = `GIST_ERR_SYSTEM;
            endcase
        end
    end

    wire engEnd = (state_q == ST_ENGINE) && xferDone;
    wire waitEnd = (state_q == ST_WAIT) && ((status & waitMask_q) != 16'h0000);
    wire sicDone = engEnd && !engFail && opCode_q == `GIST_OP_SIC;
    wire passDone = engEnd && !engFail && opCode_q == `GIST_OP_PASS;

    // ==========================================================
    // sequencer and latched result
    always @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            opCode_q <= `GIST_OP_CMD;
            waitMask_q <= 16'h0000;
            config_q <= `GIST_CFG_RESET;
            engineStart <= 1'b0;
            engineOpCode <= `GIST_OP_CMD;
            err_q <= 1'b0;
            timo_q <= 1'b0;
            errCode_q <= `GIST_ERR_SYSTEM;
            count_q <= 32'h0000_0000;
        end else begin
            engineStart <= 1'b0;
            if (cfgWrite) begin
                config_q <= pwdata;
            end
            case (state_q)
                ST_IDLE: begin
                    if (opStart) begin
                        opCode_q <= newOp;
                        waitMask_q <= pwdata[`GIST_OP_MASK_HI:`GIST_OP_MASK_LO];
                        if (preFail) begin
                            // refused at once, result visible next cycle
                            err_q <= 1'b1;
                            timo_q <= 1'b0;
                            errCode_q <= preCode;
                        end else if (newOp == `GIST_OP_WAIT) begin
                            state_q <= ST_WAIT;
                        end else begin
                            engineStart <= 1'b1;
                            engineOpCode <= newOp;
                            state_q <= ST_ENGINE;
                        end
                    end
                end
                ST_ENGINE: begin
                    if (xferDone) begin
                        state_q <= ST_IDLE;
                        err_q <= engFail;
                        timo_q <= engTimo;
                        errCode_q <= engCode;
                        // system failure detail goes to count
                        if (ioOp || (engFail && engCode == `GIST_ERR_SYSTEM)) begin
                            count_q <= xferCount;
                        end
                    end
                end
                ST_WAIT: begin
                    if (waitEnd) begin
                        state_q <= ST_IDLE;
                        err_q <= 1'b0;
                        timo_q <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // transfer abort watchers
    always @(posedge clk_sys) begin
        if (srst) begin
            dclAbort_q <= 1'b0;
            atnAbort_q <= 1'b0;
            atnPrev_q <= 1'b0;
        end else begin
            atnPrev_q <= atnLine;
            if (engineStart) begin
                dclAbort_q <= 1'b0;
                atnAbort_q <= 1'b0;
            end
            if (state_q == ST_ENGINE && ioOp) begin
                if (clrSet) begin
                    dclAbort_q <= 1'b1;
                end
                // foreign ATN during our write
                if (opCode_q == `GIST_OP_WRITE && !cic_q && atnLine && !atnPrev_q) begin
                    atnAbort_q <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // addressing and controller flags; IFC first
    always @(posedge clk_sys) begin
        if (srst) begin
            cic_q <= 1'b0;
            talk_q <= 1'b0;
            listen_q <= 1'b0;
            pendTalk_q <= 1'b0;
            pendListen_q <= 1'b0;
        end else begin
            // own clear pulse keeps its role
            if (ifcLine && !(state_q == ST_ENGINE && opCode_q == `GIST_OP_SIC)) begin
                cic_q <= 1'b0;
            end else if (sicDone || controlPassedIn) begin
                cic_q <= 1'b1;
            end else if (passDone) begin
                cic_q <= 1'b0;
            end
            if (ifcLine) begin
                talk_q <= 1'b0;
                listen_q <= 1'b0;
                pendTalk_q <= 1'b0;
                pendListen_q <= 1'b0;
            end else if (cmdByte) begin
                // set and clear never share a byte
                if (talkSet) begin
                    talk_q <= 1'b1;
                end else if (talkClr) begin
                    talk_q <= 1'b0;
                end
                if (listenSet) begin
                    listen_q <= 1'b1;
                end else if (listenClr) begin
                    listen_q <= 1'b0;
                end
                // secondary must be the next byte
                pendTalk_q <= secEn && ownTalk;
                pendListen_q <= secEn && ownListen;
            end
        end
    end

    // ==========================================================
    // trigger and clear flags; an event beats the clear
    always @(posedge clk_sys) begin
        if (srst) begin
            trig_q <= 1'b0;
            clr_q <= 1'b0;
            armTrig_q <= 1'b0;
            armClr_q <= 1'b0;
        end else begin
            if (trigSet) begin
                trig_q <= 1'b1;
            end else if (opStart && armTrig_q) begin
                trig_q <= 1'b0;
            end
            if (clrSet) begin
                clr_q <= 1'b1;
            end else if (opStart && armClr_q) begin
                clr_q <= 1'b0;
            end
            if (opStart) begin
                armTrig_q <= 1'b0;
                armClr_q <= 1'b0;
            end else if (waitEnd) begin
                armTrig_q <= waitMask_q[`GIST_ST_TRIG];
                armClr_q <= waitMask_q[`GIST_ST_CLEAR];
            end else if (engEnd && ioOp) begin
                armClr_q <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/gist_sync.v
// two-flop synchroniser for bus lines
`timescale 1ns/100ps
`default_nettype none

module gist_sync #(
    parameter WIDTH = 3
) (
    input wire clk_sys,
    input wire srst,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q; // first stage, read only by the second
    reg [WIDTH-1:0] sync_q; // second stage, safe for logic

    // ==========================================================
    // two stages, both cleared by reset
    always @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;

endmodule
`default_nettype wire

// file: tb/gist_bus_partner.sv
// transfer engine model, random reply delay
`timescale 1ns/100ps
`default_nettype none
module gist_bus_partner (
    input wire logic clk_sys,
    input wire logic engineStart,
    input wire logic [2:0] planResult,
    input wire logic [31:0] planCount,
    output logic xferDone = 1'b0,
    output logic [2:0] xferResult = 3'h0,
    output logic [31:0] xferCount = 32'h0
);
    int waitCnt = -1; // cycles to reply, -1 idle
    // ============================================================
    // one done pulse 1-8 cycles after start; lines churn between
    always @(posedge clk_sys) begin
        xferDone <= 1'b0;
        xferResult <= ~xferResult;
        xferCount <= ~xferCount;
        if (engineStart) begin
            waitCnt <= $urandom_range(7);
        end else if (waitCnt == 0) begin
            xferDone <= 1'b1;
            xferResult <= planResult;
            xferCount <= planCount;
            waitCnt <= -1;
        end else if (waitCnt > 0) begin
            waitCnt <= waitCnt - 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/gist_status_tracker_assertions.sv
// assertions on the ports of the interface status tracker
`timescale 1ns/100ps
`default_nettype none
`include "gist_map.vh"
module gist_status_tracker_assertions (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic atnPin,
    input wire logic ifcPin,
    input wire logic [7:0] busByte,
    input wire logic busByteAccepted,
    input wire logic xferDone,
    input wire logic [2:0] xferResult,
    input wire logic [15:0] statusWord,
    input wire logic opBusy
);
    // ============================================================
    // helpers
    localparam logic [4:0] MY_ADDR = 5'h0a; // bench's own address
    logic [2:0] ifcHist_q = 3'h7; // ifc over three edges
    wire logic [6:0] b = busByte[6:0]; // parity bit is ignored
    wire logic cmd = busByteAccepted && statusWord[4]; // ATN byte
    wire logic quiet = !ifcPin && ifcHist_q == 3'h0; // no ifc in reach
    wire logic ownL = cmd && quiet && b == {`GIST_GRP_LISTEN, MY_ADDR};
    wire logic ownT = cmd && quiet && b == {`GIST_GRP_TALK, MY_ADDR};
    // ifc history
    always @(posedge clk_sys) begin
        ifcHist_q <= {ifcHist_q[1:0], ifcPin};
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ============================================================
    // properties
    a_atn_mirror: assert property (!$past(srst) && !$past(srst, 2)
        |-> statusWord[4] == $past(atnPin, 2)) else $error("attention bit off the line");
    a_idle_after: assert property (opBusy && xferDone |=> !opBusy && statusWord[8])
        else $error("no idle after done");
    a_err_fail: assert property (opBusy && xferDone && xferResult != 3'h0 |=> statusWord[15])
        else $error("failure without error bit");
    a_ifc_clear: assert property (ifcPin [*5] |-> statusWord[3:2] == 2'b00)
        else $error("addressing survived ifc");
    a_own_listen: assert property (ownL |=> statusWord[3:2] == 2'b01)
        else $error("own listen address mishandled");
    a_own_talk: assert property (ownT |=> statusWord[3:2] == 2'b10)
        else $error("own talk address mishandled");
    a_trig_get: assert property (cmd && b == `GIST_CMD_GET && statusWord[2] |=> statusWord[1])
        else $error("trigger not flagged");
    a_dcl_flag: assert property (cmd && b == `GIST_CMD_DCL |=> statusWord[0])
        else $error("device clear not flagged");
    a_data_ignored: assert property (busByteAccepted && !statusWord[4] && quiet
        |=> $stable(statusWord[3:2])) else $error("data byte changed addressing");
endmodule
`default_nettype wire

// file: tb/test_gist_status_tracker.sv
// bench for the status tracker
`timescale 1ns/100ps
`default_nettype none
`include "gist_map.vh"
module test_gist_status_tracker;
    // ============================================================
    // signals
    localparam logic [7:0] ST = `GIST_ADDR_STATUS, ER = `GIST_ADDR_ERROR, CN = `GIST_ADDR_COUNT;
    logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic atnPin = 1'b0, ifcPin = 1'b0, acc = 1'b0, passIn = 1'b0, srq = 1'b0;
    logic pready, pslverr, start, xferDone, opBusy;
    logic [7:0] paddr = 8'h00, busByte = 8'h00;
    logic [31:0] pwdata = 32'h0, count = 32'h0, prdata, cnt;
    logic [2:0] res = 3'h0, xferResult;
    logic [3:0] opCode, lastOp;
    logic [15:0] statusWord;
    logic [32:0] expQ[$]; // expected reads
    logic [3:0] errMap [5] = '{4'h0, 4'h2, 4'h6, 4'he, 4'h0};
    logic [3:0] cicOps [4] = '{4'h0, 4'h3, 4'h5, 4'h7};
    int error_cnt = 0, n_checks = 0, cyc = 0, i;
    initial forever #2.5 clk_sys = ~clk_sys;
    gist_status_tracker dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .atnPin(atnPin), .ifcPin(ifcPin), .srqPin(srq), .busByte(busByte),
        .busByteAccepted(acc), .controlPassedIn(passIn), .engineStart(start),
        .engineOpCode(opCode), .xferDone(xferDone), .xferResult(xferResult), .xferCount(cnt),
        .statusWord(statusWord), .opBusy(opBusy));
    gist_bus_partner eng (.clk_sys(clk_sys), .engineStart(start), .planResult(res),
        .planCount(count), .xferDone(xferDone), .xferResult(xferResult), .xferCount(cnt));
    // ============================================================
    // tasks
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // start an operation, wait until idle
    task automatic op(input logic [3:0] c, input logic [15:0] m, input logic [2:0] r);
        lastOp = c;
        res <= r;
        count <= $urandom;
        apb(1'b1, `GIST_ADDR_OP, {m, 12'h0, c});
        repeat (2) @(posedge clk_sys);
        while (opBusy !== 1'b0) @(posedge clk_sys);
    endtask
    // one bus byte, after line changes settle
    task automatic bus(input logic [6:0] v);
        repeat (3) @(posedge clk_sys);
        busByte <= {1'($urandom), v};
        acc <= 1'b1;
        @(posedge clk_sys);
        acc <= 1'b0;
        busByte <= ~busByte;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ============================================================
    // read monitor and watchdog
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
            chk({pslverr, prdata}, expQ.pop_front());
        end
        if (start === 1'b1) chk(33'(opCode), 33'(lastOp));
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            summarize();
        end
    end
    // ============================================================
    // main sequence
    initial begin
        i = $urandom(61466);
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        rd(ST, 32'h0100);
        rd(8'h14, 33'h1_0000_0000);
        op(`GIST_OP_SIC, 16'h0, 3'h0);
        rd(ST, 32'h8100);
        rd(ER, 32'h5);
        for (i = 0; i < 4; i++) begin
            op(cicOps[i], 16'h0, 3'h0);
            rd(ER, 32'h1);
        end
        apb(1'b1, `GIST_ADDR_CONFIG, 32'h0002_000a);
        op(`GIST_OP_SIC, 16'h0, 3'h0);
        rd(ST, 32'h0120);
        op(`GIST_OP_PPOLL, 16'h0, 3'h0);
        rd(ER, 32'hb);
        op(`GIST_OP_READ, 16'h0, 3'h0);
        rd(ER, 32'h3);
        op(`GIST_OP_WAIT, 16'h0020, 3'h0);
        atnPin <= 1'b1;
        bus(7'h2a);
        bus(`GIST_CMD_GET);
        bus(`GIST_CMD_DCL);
        rd(ST, 32'h0137);
        bus(7'h4a);
        rd(ST, 32'h013b);
        atnPin <= 1'b0;
        bus(`GIST_CMD_UNT);
        rd(ST, 32'h012b);
        op(`GIST_OP_WAIT, 16'h0003, 3'h0);
        for (i = 1; i < 5; i++) begin
            op(`GIST_OP_WRITE, 16'h0, 3'(i));
            rd(ST, (i == 2 || i == 3) ? 32'hc128 : 32'h8128);
            rd(ER, {28'h0, errMap[i]});
            rd(CN, count);
        end
        op(`GIST_OP_WRITE, 16'h0, 3'h0);
        rd(ST, 32'h0128);
        rd(CN, count);
        atnPin <= 1'b1;
        bus(`GIST_CMD_DCL);
        bus(7'h43);
        rd(ST, 32'h0131);
        op(`GIST_OP_PASS, 16'h0, 3'h0);
        rd(ST, 32'h0110);
        passIn <= 1'b1;
        srq <= 1'b1;
        @(posedge clk_sys);
        passIn <= 1'b0;
        rd(ST, 32'h1130);
        ifcPin <= 1'b1;
        bus(7'h2a);
        rd(ST, 32'h0110);
        ifcPin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        summarize();
    end
endmodule
bind gist_status_tracker gist_status_tracker_assertions asrt (.clk_sys(clk_sys), .srst(srst),
    .atnPin(atnPin), .ifcPin(ifcPin), .busByte(busByte), .busByteAccepted(busByteAccepted),
    .xferDone(xferDone), .xferResult(xferResult), .statusWord(statusWord), .opBusy(opBusy));
`default_nettype wire
